// file: rtl/fie_pkg.sv
// package for the float/integer/exponent execution block
// assumes an apb master on the single processor clock
package fie_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] FIE_CTRL_OFS   = 8'h00;
   localparam logic [7:0] FIE_ACCHI_OFS  = 8'h04;
   localparam logic [7:0] FIE_ACCLO_OFS  = 8'h08;
   localparam logic [7:0] FIE_SRC_OFS    = 8'h0C;
   localparam logic [7:0] FIE_CMD_OFS    = 8'h10;
   localparam logic [7:0] FIE_RESULT_OFS = 8'h14;
   localparam logic [7:0] FIE_STATUS_OFS = 8'h18;

   // ----------------------------------------------------------------
   // control field positions and reset values
   // ----------------------------------------------------------------
   localparam int FIE_CTRL_W       = 9;
   localparam int FIE_LONG_BIT     = 0;
   localparam int FIE_DOUBLE_BIT   = 1;
   localparam int FIE_CHOP_BIT     = 2;
   localparam int FIE_UNDEFTE_BIT  = 3;
   localparam int FIE_CONVTE_BIT   = 4;
   localparam int FIE_OVFTE_BIT    = 5;
   localparam int FIE_UNFTE_BIT    = 6;
   localparam int FIE_DSTREG_BIT   = 7;
   localparam int FIE_VARIANT_BIT  = 8;
   localparam logic [FIE_CTRL_W-1:0] FIE_CTRL_RST = 9'h000;
   localparam logic [63:0] FIE_ACC_RST = 64'h0000_0000_0000_0000;

   // status field positions
   localparam int FIE_ST_FPU_LSB  = 0;
   localparam int FIE_ST_CPU_LSB  = 4;
   localparam int FIE_ST_TRAP_BIT = 8;
   localparam int FIE_ST_CAUSE_LSB = 9;
   localparam int FIE_ST_BUSY_BIT = 11;

   // ----------------------------------------------------------------
   // number format constants
   // ----------------------------------------------------------------
   localparam logic [7:0]         FIE_POW_BIAS  = 8'h80;
   localparam logic signed [15:0] FIE_SRC_MAX   = 16'sh007F;
   localparam logic signed [15:0] FIE_SRC_MIN   = 16'shFF81;
   localparam logic [33:0]        FIE_BOUND_W   = 34'h0_0000_7FFF;
   localparam logic [33:0]        FIE_BOUND_L   = 34'h0_7FFF_FFFF;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FIE_OP_STCONV = 2'b00,
      FIE_OP_LDPOW  = 2'b01,
      FIE_OP_STPOW  = 2'b11,
      FIE_OP_CLEAR  = 2'b10
   } fie_op_e;

   typedef enum logic [1:0] {
      FIE_TRAP_NONE = 2'b00,
      FIE_TRAP_CONV = 2'b01,
      FIE_TRAP_OVF  = 2'b10,
      FIE_TRAP_UNF  = 2'b11
   } fie_trap_e;

   typedef enum logic {
      FIE_ST_IDLE = 1'b0,
      FIE_ST_EXEC = 1'b1
   } fie_fsm_e;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } fie_flags_s;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } fie_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } fie_apb_rsp_s;

endpackage : fie_pkg

// file: rtl/fie_exec.sv
// float/integer/exponent execution block with its apb register file
// assumes one 100 MHz clock, asynchronous active-low reset, apb master
//
// Overview of operation
// RL1: store-as-integer converts the accumulator to two's complement, width from long select, precision from double select.
// RL2: the integer bound is 2**15-1 for word and 2**31-1 for long, and in range means strictly inside -bound-1 .. bound+1.
// RL3: an out-of-range conversion stores zero and sets the carry flag, otherwise the carry flag is cleared.
// RL4: a long conversion to a register or immediate destination stores only the upper 16 bits.
// RL5: conversion always chops toward the integer part whatever the chop mode bit says.
// RL6: conversion never traps on minus zero and traps on failure only with the conversion trap enable set.
// RL7: load power with source inside -128..128 writes source plus 128 into the power field and keeps the rest.
// RL8: load power above 127 with overflow trap enabled traps, variant one loads bits 6:0, variant two bits 7:0, overflow set.
// RL9: load power above 127 without overflow trap zeroes the accumulator on variant one, loads source plus 128 on variant two.
// RL10: load power below -127 without underflow trap zeroes the accumulator on both variants.
// RL11: load power below -127 with underflow trap traps, variant one loads bits 6:0, variant two source plus 128.
// RL12: load power never traps on minus zero even with the undefined variable trap enable set.
// RL13: the hidden bit counts only when the power field is non-zero, so a loaded power revives a zero accumulator.
// RL14: clear writes exact zero, sets the zero flag and clears carry, overflow and negative.
// RL15: clear never traps, overflows or underflows.
// RL16: store power writes the power field minus 128, clears carry and overflow, sets zero and negative from the result and copies codes.
// RL17: after store-as-integer overflow is cleared, zero and negative follow the stored value, all four flags are copied.
`timescale 1ns/10ps
`default_nettype none

module fie_exec
   import fie_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // apb slave
   input  wire fie_pkg::fie_apb_req_s apbReq,
   output var  fie_pkg::fie_apb_rsp_s apbRsp
);
   import fie_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      fie_fsm_e              fsm;
      fie_op_e               op;
      logic [FIE_CTRL_W-1:0] ctrl;
      logic [63:0]           acc;
      logic [15:0]           src;
      logic [31:0]           result;
      fie_flags_s            fpuFlags;
      fie_flags_s            cpuFlags;
      logic                  trapPend;
      fie_trap_e             trapCause;
      logic [31:0]           rdata;
   } fie_state_s;

   typedef struct packed {
      logic        outOfRange;
      logic [31:0] value;
   } fie_conv_s;

   fie_state_s cur;
   fie_state_s next_cur;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == FIE_CTRL_OFS) || (a == FIE_ACCHI_OFS) || (a == FIE_ACCLO_OFS) ||
                 (a == FIE_SRC_OFS) || (a == FIE_CMD_OFS) || (a == FIE_RESULT_OFS) ||
                 (a == FIE_STATUS_OFS);
   endfunction : isMapped

   function automatic logic [31:0] readMux(input fie_state_s s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         FIE_CTRL_OFS:   r = {23'h00_0000, s.ctrl};
         FIE_ACCHI_OFS:  r = s.acc[63:32];
         FIE_ACCLO_OFS:  r = s.acc[31:0];
         FIE_SRC_OFS:    r = {16'h0000, s.src};
         FIE_RESULT_OFS: r = s.result;
         FIE_STATUS_OFS: begin
            r[FIE_ST_FPU_LSB +: 4]   = s.fpuFlags;
            r[FIE_ST_CPU_LSB +: 4]   = s.cpuFlags;
            r[FIE_ST_TRAP_BIT]       = s.trapPend;
            r[FIE_ST_CAUSE_LSB +: 2] = s.trapCause;
            r[FIE_ST_BUSY_BIT]       = (s.fsm == FIE_ST_EXEC);
         end
         default:        r = 32'h0000_0000;
      endcase
      readMux = r;
   endfunction : readMux

   // chops toward zero: bits below the binary point are simply dropped
   function automatic fie_conv_s toInteger(input logic [63:0] a, input logic dbl,
                                           input logic lng);
      logic [55:0]      mant;
      logic signed [9:0] k;
      logic [33:0]      mag;
      logic [33:0]      bound;
      fie_conv_s        r;
      mant  = {1'b1, a[54:0]};
      k     = $signed({2'b00, a[62:55]}) - $signed({2'b00, FIE_POW_BIAS});
      mag   = 34'h0_0000_0000;
      bound = lng ? FIE_BOUND_L : FIE_BOUND_W;                          // see RL2
      r.outOfRange = 1'b0;
      if (!dbl) begin
         mant[31:0] = 32'h0000_0000;                                     // see RL1
      end
      if (a[62:55] == 8'h00 || k <= 10'sd0) begin                        // see RL13
         mag = 34'h0_0000_0000;
      end else if (k > 10'sd33) begin
         r.outOfRange = 1'b1;
      end else begin
         mag = 34'(mant >> (7'd56 - 7'(k)));                             // see RL5
      end
      // strict on both sides, so minus bound minus one is refused as well
      if (mag > bound) begin                                             // see RL2
         r.outOfRange = 1'b1;
      end
      r.value = a[63] ? 32'(34'h0 - mag) : mag[31:0];                    // see RL1
      toInteger = r;
   endfunction : toInteger

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic              wrAcc;
      logic [7:0]        ad;
      logic signed [15:0] srcS;
      logic [7:0]        sumPow;
      logic [15:0]       powDiff;
      logic [31:0]       stored;
      logic              storedNeg;
      logic              lng;
      logic              variantTwo;
      fie_conv_s         conv;
      wrAcc      = apbReq.psel && apbReq.penable && apbReq.pwrite;
      ad         = apbReq.paddr;
      srcS       = $signed(cur.src);
      sumPow     = cur.src[7:0] + FIE_POW_BIAS;
      powDiff    = {8'h00, cur.acc[62:55]} - {8'h00, FIE_POW_BIAS};
      lng        = cur.ctrl[FIE_LONG_BIT];
      variantTwo = cur.ctrl[FIE_VARIANT_BIT];
      conv       = toInteger(cur.acc, cur.ctrl[FIE_DOUBLE_BIT], lng);
      stored     = 32'h0000_0000;
      storedNeg  = 1'b0;
      next_cur   = cur;

      // register writes; a clear of the trap bit loses to a new trap below
      if (wrAcc) begin
         case (ad)
            FIE_CTRL_OFS:   next_cur.ctrl        = apbReq.pwdata[FIE_CTRL_W-1:0];
            FIE_ACCHI_OFS:  next_cur.acc[63:32]  = apbReq.pwdata;
            FIE_ACCLO_OFS:  next_cur.acc[31:0]   = apbReq.pwdata;
            FIE_SRC_OFS:    next_cur.src         = apbReq.pwdata[15:0];
            FIE_CMD_OFS: begin
               if (cur.fsm == FIE_ST_IDLE) begin
                  next_cur.op  = fie_op_e'(apbReq.pwdata[1:0]);
                  next_cur.fsm = FIE_ST_EXEC;
               end
            end
            FIE_STATUS_OFS: begin
               if (apbReq.pwdata[FIE_ST_TRAP_BIT]) begin
                  next_cur.trapPend  = 1'b0;
                  next_cur.trapCause = FIE_TRAP_NONE;
               end
            end
            default: ;
         endcase
      end

      // execution, one cycle after the command write
      if (cur.fsm == FIE_ST_EXEC) begin
         next_cur.fsm = FIE_ST_IDLE;
         case (cur.op)
            FIE_OP_STCONV: begin
               if (!conv.outOfRange) begin
                  if (lng && cur.ctrl[FIE_DSTREG_BIT]) begin                 // see RL4
                     stored    = {16'h0000, conv.value[31:16]};
                     storedNeg = conv.value[31];
                  end else if (lng) begin
                     stored    = conv.value;
                     storedNeg = conv.value[31];
                  end else begin
                     stored    = {16'h0000, conv.value[15:0]};
                     storedNeg = conv.value[15];
                  end
               end
               next_cur.result     = stored;                                 // see RL3
               next_cur.fpuFlags.c = conv.outOfRange;                        // see RL3
               next_cur.fpuFlags.v = 1'b0;                                   // see RL17
               next_cur.fpuFlags.z = (stored == 32'h0000_0000);              // see RL17
               next_cur.fpuFlags.n = storedNeg;                              // see RL17
               next_cur.cpuFlags   = {storedNeg, stored == 32'h0000_0000,
                                      1'b0, conv.outOfRange};                // see RL17
               // no minus-zero check here: the operand stays in the accumulator
               if (conv.outOfRange && cur.ctrl[FIE_CONVTE_BIT]) begin        // see RL6
                  next_cur.trapPend  = 1'b1;
                  next_cur.trapCause = FIE_TRAP_CONV;
               end
            end
            FIE_OP_LDPOW: begin
               // the undefined-variable enable is never consulted here  // see RL12
               if (srcS > FIE_SRC_MAX) begin
                  if (cur.ctrl[FIE_OVFTE_BIT]) begin                         // see RL8
                     next_cur.acc[62:55] = variantTwo ? cur.src[7:0] : {1'b0, cur.src[6:0]};
                     next_cur.trapPend   = 1'b1;
                     next_cur.trapCause  = FIE_TRAP_OVF;
                  end else if (variantTwo) begin                             // see RL9
                     next_cur.acc[62:55] = sumPow;
                  end else begin
                     next_cur.acc = FIE_ACC_RST;                             // see RL9
                  end
               end else if (srcS < FIE_SRC_MIN) begin
                  if (cur.ctrl[FIE_UNFTE_BIT]) begin                         // see RL11
                     next_cur.acc[62:55] = variantTwo ? sumPow : {1'b0, cur.src[6:0]};
                     next_cur.trapPend   = 1'b1;
                     next_cur.trapCause  = FIE_TRAP_UNF;
                  end else begin
                     next_cur.acc = FIE_ACC_RST;                             // see RL10
                  end
               end else begin
                  next_cur.acc[62:55] = sumPow;                              // see RL7
               end
               next_cur.fpuFlags.c = 1'b0;
               next_cur.fpuFlags.v = (srcS > FIE_SRC_MAX);                   // see RL8
               next_cur.fpuFlags.z = (next_cur.acc[62:55] == 8'h00);         // see RL13
               next_cur.fpuFlags.n = next_cur.acc[63];
            end
            FIE_OP_STPOW: begin
               next_cur.result   = {{16{powDiff[15]}}, powDiff};              // see RL16
               next_cur.fpuFlags = {powDiff[15], powDiff == 16'h0000, 2'b00}; // see RL16
               next_cur.cpuFlags = {powDiff[15], powDiff == 16'h0000, 2'b00}; // see RL16
            end
            FIE_OP_CLEAR: begin
               next_cur.acc      = FIE_ACC_RST;                              // see RL14
               next_cur.fpuFlags = 4'b0100;                                  // see RL14
               // nothing here can raise a trap                          // see RL15
            end
            default: ;
         endcase
      end

      // read data is taken in the setup phase from the state the access sees
      if (apbReq.psel && !apbReq.penable) begin
         next_cur.rdata = readMux(next_cur, ad);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur <= '{fsm: FIE_ST_IDLE, op: FIE_OP_STCONV, ctrl: FIE_CTRL_RST, acc: FIE_ACC_RST,
                  src: 16'h0000, result: 32'h0000_0000, fpuFlags: 4'h0, cpuFlags: 4'h0,
                  trapPend: 1'b0, trapCause: FIE_TRAP_NONE, rdata: 32'h0000_0000};
      end else begin
         cur <= next_cur;
      end
   end

   // -----------------------------------------------------------------
   // apb answer: zero wait states, error on unmapped offsets
   // -----------------------------------------------------------------
   always_comb begin
      apbRsp.prdata  = cur.rdata;
      apbRsp.pready  = 1'b1;
      apbRsp.pslverr = apbReq.psel && apbReq.penable && !isMapped(apbReq.paddr);
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic execConv;
   logic execLd;
   logic execSt;
   logic execClr;
   assign execConv = (cur.fsm == FIE_ST_EXEC) && (cur.op == FIE_OP_STCONV);
   assign execLd   = (cur.fsm == FIE_ST_EXEC) && (cur.op == FIE_OP_LDPOW);
   assign execSt   = (cur.fsm == FIE_ST_EXEC) && (cur.op == FIE_OP_STPOW);
   assign execClr  = (cur.fsm == FIE_ST_EXEC) && (cur.op == FIE_OP_CLEAR);

   logic lngBit;
   logic dstBit;
   assign lngBit = cur.ctrl[FIE_LONG_BIT];
   assign dstBit = cur.ctrl[FIE_DSTREG_BIT];

   sequence cmdAccepted;
      apbReq.psel && apbReq.penable && apbReq.pwrite && apbReq.paddr == FIE_CMD_OFS &&
      cur.fsm == FIE_ST_IDLE;
   endsequence
   sequence execThenIdle;
      cur.fsm == FIE_ST_EXEC ##1 cur.fsm == FIE_ST_IDLE;
   endsequence

   chk_cmd_exec_once: assert property (cmdAccepted |=> execThenIdle) // see RL1
      else $error("command did not execute exactly once");
   chk_conv_zero_store: assert property (execConv |=> (!cur.fpuFlags.c ||
      cur.result == 32'h0000_0000)) // see RL3
      else $error("out-of-range conversion stored a non-zero value");
   chk_conv_word_width: assert property (execConv && (!lngBit || dstBit) |=>
      cur.result[31:16] == 16'h0000) // see RL4
      else $error("word or register result wider than 16 bits");
   chk_conv_no_trap: assert property (execConv && !cur.ctrl[FIE_CONVTE_BIT] &&
      !cur.trapPend |=> !cur.trapPend) // see RL6
      else $error("conversion trapped with its enable clear");
   chk_conv_codes: assert property (execConv |=> cur.cpuFlags == cur.fpuFlags &&
      !cur.fpuFlags.v && cur.fpuFlags.z == (cur.result == 32'h0000_0000)) // see RL17
      else $error("conversion condition codes wrong");
   chk_load_power_instr_in_range: assert property (execLd && $signed(cur.src) <= FIE_SRC_MAX &&
      $signed(cur.src) >= FIE_SRC_MIN |=> cur.acc[62:55] == $past(cur.src[7:0]) + 8'h80 &&
      cur.acc[63] == $past(cur.acc[63]) && cur.acc[54:0] == $past(cur.acc[54:0])) // see RL7
      else $error("load power in range gave wrong accumulator");
   chk_load_power_instr_ovf_trap: assert property (execLd && $signed(cur.src) > FIE_SRC_MAX &&
      cur.ctrl[FIE_OVFTE_BIT] |=> cur.trapPend && cur.trapCause == FIE_TRAP_OVF &&
      cur.fpuFlags.v) // see RL8
      else $error("load power overflow did not trap");
   chk_load_power_instr_unf_zero: assert property (execLd && $signed(cur.src) < FIE_SRC_MIN &&
      !cur.ctrl[FIE_UNFTE_BIT] |=> cur.acc == 64'h0000_0000_0000_0000) // see RL10
      else $error("load power underflow did not clear accumulator");
   chk_load_power_instr_ovf_quiet: assert property (execLd && $signed(cur.src) > FIE_SRC_MAX &&
      !cur.ctrl[FIE_OVFTE_BIT] |=> ($past(cur.ctrl[FIE_VARIANT_BIT]) ? cur.acc[62:55] ==
      $past(cur.src[7:0]) + FIE_POW_BIAS : cur.acc == 64'h0000_0000_0000_0000)) // see RL9
      else $error("load power overflow without trap gave wrong accumulator");
   chk_load_power_instr_unf_trap: assert property (execLd && $signed(cur.src) < FIE_SRC_MIN &&
      cur.ctrl[FIE_UNFTE_BIT] |=> cur.trapPend && cur.trapCause == FIE_TRAP_UNF &&
      !cur.fpuFlags.v) // see RL11
      else $error("load power underflow did not trap");
   chk_load_power_instr_no_undef: assert property (execLd && !cur.trapPend &&
      $signed(cur.src) <= FIE_SRC_MAX && $signed(cur.src) >= FIE_SRC_MIN |=>
      !cur.trapPend) // see RL12
      else $error("load power raised a trap inside its range");
   chk_load_power_instr_zero_flag: assert property (execLd |=>
      cur.fpuFlags.z == (cur.acc[62:55] == 8'h00)) // see RL13
      else $error("load power zero flag does not follow the power field");
   chk_clear_no_trap: assert property (execClr |=>
      !cur.trapPend || $past(cur.trapPend)) // see RL15
      else $error("clear raised a trap");
   chk_store_power_instr_value: assert property (execSt |=> cur.result[15:0] ==
      {8'h00, $past(cur.acc[62:55])} - 16'h0080 && cur.cpuFlags == cur.fpuFlags) // see RL16
      else $error("store power result wrong");
   chk_clear_result: assert property (execClr && !cur.trapPend |=> cur.acc == 64'h0 &&
      cur.fpuFlags == 4'b0100 && !cur.trapPend) // see RL14
      else $error("clear did not give exact zero and zero flag");

endmodule : fie_exec

`default_nettype wire

// file: verification/fie_host_model.sv
// host model: apb master standing in for the issuing processor
// assumes a slave on clk that answers with pready, at once or later
`timescale 1ns/10ps
`default_nettype none
module fie_host_model
   import fie_pkg::*;
(
   // clock
   input  wire logic                  clk,
   // apb master side
   output var  fie_pkg::fie_apb_req_s apbReq,
   input  wire fie_pkg::fie_apb_rsp_s apbRsp
);
   import fie_pkg::*;
   initial apbReq = '0;
   // request held whole until pready is seen at an edge, never released early
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk);
      apbReq.psel    <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite  <= wr;
      apbReq.paddr   <= adr;
      apbReq.pwdata  <= dat;
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do @(posedge clk); while (apbRsp.pready !== 1'b1);
      apbReq.psel    <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask : xfer
endmodule : fie_host_model
`default_nettype wire

// file: verification/fie_exec_tb.sv
// testbench for the float/integer/exponent block
// assumes the host model as apb master; results checked from a note queue
`timescale 1ns/10ps
`default_nettype none
module fie_exec_tb;
   import fie_pkg::*;
   typedef struct packed {logic [31:0] val; logic [31:0] mask; logic err;} fie_note_s;
   logic         clk;
   logic         rst_b;
   fie_apb_req_s apbReq;
   fie_apb_rsp_s apbRsp;
   fie_note_s    notes[$];
   int           badCount = 0;
   int           nCompared = 0;
   int           cycles = 0;
   logic [31:0]  seed;
   // conversion cases: control, accumulator, result, status
   logic [31:0] cCtl[9] = '{9'h000, 9'h004, 9'h000, 9'h000, 9'h010, 9'h081, 9'h001, 9'h009, 9'h002};
   logic [31:0] cAcc[9] = '{32'h4160_0000, 32'hC160_0000, 32'h47FF_FE00, 32'h4800_0000,
      32'hC800_0000, 32'h4940_0000, 32'h4940_0000, 32'h4800_0000, 32'h4140_0000};
   logic [31:0] cRes[9] = '{32'h0000_0003, 32'h0000_FFFD, 32'h0000_7FFF, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0003, 32'h0003_0000, 32'h0000_8000, 32'h0000_0003};
   logic [31:0] cSt[9] = '{12'h000, 12'h088, 12'h000, 12'h055, 12'h355, 12'h000, 12'h000,
      12'h000, 12'h000};
   // load power out-of-range cases on a negative accumulator
   logic [31:0] lCtl[8] = '{9'h028, 9'h128, 9'h008, 9'h108, 9'h008, 9'h108, 9'h048, 9'h148};
   logic [31:0] lSrc[8] = '{16'h00C8, 16'h00C8, 16'h00C8, 16'h00C8, 16'hFF38, 16'hFF38,
      16'hFF38, 16'hFF38};
   logic [31:0] lAcc[8] = '{32'hA440_0000, 32'hE440_0000, 32'h0000_0000, 32'hA440_0000,
      32'h0000_0000, 32'h0000_0000, 32'h9C40_0000, 32'hDC40_0000};
   logic [31:0] lSt[8] = '{12'h50A, 12'h50A, 12'h006, 12'h00A, 12'h004, 12'h004, 12'h708,
      12'h708};

   fie_exec dut_u (.clk(clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp));
   fie_host_model host_u (.clk(clk), .apbReq(apbReq), .apbRsp(apbRsp));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction : lfsr

   task automatic finalReport();
      if (badCount == 0 && nCompared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finalReport

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d);
   endtask : wr

   task automatic chk(input logic [7:0] a, input logic [31:0] v,
                      input logic [31:0] m = 32'hFFFF_FFFF, input logic e = 1'b0);
      notes.push_back('{v & m, m, e});
      host_u.xfer(1'b0, a, 32'h0000_0000);
   endtask : chk

   task automatic op(input fie_op_e o);
      wr(FIE_CMD_OFS, {30'h0000_0000, o});
   endtask : op

   // ----------------------------------------------------------------
   // monitor: oldest note against each completed read
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      fie_note_s n;
      cycles++;
      if (cycles == 3000) begin
         badCount++;
         finalReport();
      end
      if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1 && !apbReq.pwrite) begin
         n = notes.pop_front();
         nCompared++;
         if ((apbRsp.prdata & n.mask) !== n.val || apbRsp.pslverr !== n.err) begin
            badCount++;
            $display("MISMATCH read %h expected %h/%b seen %h/%b", apbReq.paddr, n.val,
                     n.err, apbRsp.prdata & n.mask, apbRsp.pslverr);
         end
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic signed [15:0] s;
      rst_b = 1'b0;
      seed = 32'hd67c;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      chk(FIE_CTRL_OFS, 32'h0000_0000);
      chk(FIE_STATUS_OFS, 32'h0000_0000, 32'h0000_07FF);
      for (int i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         wr(FIE_CTRL_OFS, cCtl[i]);
         wr(FIE_ACCHI_OFS, cAcc[i]);
         wr(FIE_ACCLO_OFS, seed);
         op(FIE_OP_STCONV);
         chk(FIE_RESULT_OFS, cRes[i]);
         chk(FIE_STATUS_OFS, cSt[i], 32'h0000_07FF);
         wr(FIE_STATUS_OFS, 32'h0000_0100);
      end
      for (int i = 0; i < 8; i++) begin
         wr(FIE_CTRL_OFS, lCtl[i]);
         wr(FIE_ACCHI_OFS, 32'hC140_0000);
         wr(FIE_SRC_OFS, lSrc[i]);
         op(FIE_OP_LDPOW);
         chk(FIE_ACCHI_OFS, lAcc[i]);
         chk(FIE_STATUS_OFS, lSt[i], 32'h0000_070F);
         wr(FIE_STATUS_OFS, 32'h0000_0100);
      end
      wr(FIE_CTRL_OFS, 32'h0000_0008);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         s = (i == 0) ? 16'sh007F : (i == 1) ? 16'shFF81 : 16'(seed % 255) - 16'sh007F;
         wr(FIE_ACCHI_OFS, 32'h0000_0000);
         wr(FIE_SRC_OFS, {16'h0000, s});
         op(FIE_OP_LDPOW);
         chk(FIE_ACCHI_OFS, {1'b0, s[7:0] + 8'h80, 23'h00_0000});
         chk(FIE_STATUS_OFS, 32'h0000_0000, 32'h0000_070F);
      end
      wr(FIE_ACCHI_OFS, 32'h4140_0000);
      op(FIE_OP_STPOW);
      chk(FIE_RESULT_OFS, 32'h0000_0002);
      wr(FIE_ACCHI_OFS, 32'h8000_0000);
      op(FIE_OP_STPOW);
      chk(FIE_RESULT_OFS, 32'hFFFF_FF80);
      chk(FIE_STATUS_OFS, 32'h0000_0088, 32'h0000_07FF);
      wr(FIE_ACCHI_OFS, 32'h4800_0000);
      wr(FIE_CTRL_OFS, 32'h0000_0070);
      op(FIE_OP_STCONV);
      wr(FIE_STATUS_OFS, 32'h0000_0100);
      wr(FIE_ACCHI_OFS, 32'hC140_0000);
      wr(FIE_ACCLO_OFS, seed);
      op(FIE_OP_CLEAR);
      chk(FIE_ACCHI_OFS, 32'h0000_0000);
      chk(FIE_ACCLO_OFS, 32'h0000_0000);
      chk(FIE_STATUS_OFS, 32'h0000_0004, 32'h0000_070F);
      wr(8'h1C, 32'hFFFF_FFFF);
      chk(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
      finalReport();
   end
endmodule : fie_exec_tb
`default_nettype wire
